// ===== mis_pkg.sv
/*
 * Shared constants for the monitor two-wire slave interface: bus
 * addresses, command page, pin codes, timeout figures and FSM states.
 * Assumes a single 50 MHz system clock for every user of the package.
 */
package mis_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned BUS_TIMEOUT_MS = 25;
   // Least time, rounded up to whole cycles
   localparam int unsigned TIMEOUT_CYCLES =
      (CLK_HZ * BUS_TIMEOUT_MS + 999) / 1000;
   localparam int unsigned TMO_CNT_W = 21;

   // ----------------------------------------------------------------
   // Bus addresses and commands
   // ----------------------------------------------------------------
   localparam logic [7:0] MASS_WR_ADDR = 8'hC6;
   localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
   // Upper five command bits: manufacturer page D0..D7
   localparam logic [4:0] CMD_PAGE = 5'h1A;

   // ----------------------------------------------------------------
   // Three-state address pin codes
   // ----------------------------------------------------------------
   localparam logic [1:0] PIN_LO = 2'h0;
   localparam logic [1:0] PIN_HI = 2'h1;
   localparam logic [1:0] PIN_OPEN = 2'h2;

   // ----------------------------------------------------------------
   // Reset values and states
   // ----------------------------------------------------------------
   localparam logic [2:0] PTR_RST = 3'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [2:0] BIT_LAST = 3'h7;

   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_ADDR = 9'h002,
      ST_AACK = 9'h004,
      ST_CMD  = 9'h008,
      ST_CACK = 9'h010,
      ST_WDAT = 9'h020,
      ST_WACK = 9'h040,
      ST_TX   = 9'h080,
      ST_MACK = 9'h100
   } mis_state_t;

endpackage

// ===== mis_bus_timer.sv
/*
 * Stuck-bus timer: counts clock cycles while either bus line is low.
 * Assumes its line inputs are already synchronised to clock.
 */
`timescale 1ns/1ps
module mis_bus_timer
   import mis_pkg::*;
#(
   parameter int unsigned LIMIT = TIMEOUT_CYCLES,
   parameter int unsigned CW = TMO_CNT_W
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Synchronised bus lines
   input wire logic scl_s,
   input wire logic sda_s,
   // One-cycle expiry pulse
   output logic expired
);

   logic [CW-1:0] cnt_r;
   wire logic both_hi = scl_s & sda_s;
   wire logic at_limit = (cnt_r == CW'(LIMIT));
   wire logic hit_now = (cnt_r == CW'(LIMIT - 1));

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r <= '0;
         expired <= 1'b0;
      end
      else
      begin
         // Any idle cycle restarts it; only a continuous low counts
         if (both_hi)
            cnt_r <= '0;
         else if (!at_limit)
            cnt_r <= cnt_r + CW'(1);
         expired <= !both_hi && hit_now;
      end
   end

endmodule // mis_bus_timer

// ===== mis_i2c_slave.sv
/*
 * Two-wire slave interface of the monitor: address match, command
 * check, byte and word transfers, alert response, stuck-bus timeout.
 * Assumes an external register file on clock that answers rd_data for
 * reg_ptr combinationally and takes wr_data on wr_strobe.
 */
// Functional notes
// - Addressed slave taking byte/word reads and writes.
// - Word read: second byte is the following register.
// - Word write: only the first data byte is stored.
// - Either line low beyond 25 ms resets interface, releases data.
// - Unsupported command byte is not acknowledged.
// - Command codes sit in the manufacturer command page.
// - SDA falling while SCL high is a start.
// - SDA rising while SCL high is a stop; bus free.
// - Acknowledged command loads its low three bits into the pointer.
// - Mass write address answered unless mass write disabled.
// - Alert response address answered while alert active, with own address, alert released.
// - Address from three three-state pins, twenty-four distinct addresses.
`timescale 1ns/1ps
module mis_i2c_slave
   import mis_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = TIMEOUT_CYCLES,
   parameter logic [2:0] ADR_HL_LOW3 = 3'h0
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Bus pins
   input wire logic scl_pin,
   input wire logic sda_pin,
   output logic serial_data_out_pin,
   output logic serial_data_out_pin_oe,
   // Address straps: 0 low, 1 high, 2 open
   input wire logic [1:0] addr_select_pin_lo,
   input wire logic [1:0] addr_select_pin_mid,
   input wire logic [1:0] addr_select_pin_hi,
   // Alert and mass write control
   input wire logic alert_active,
   input wire logic mass_write_en,
   output logic alert_release,
   // Register file side
   output logic [2:0] reg_ptr,
   input wire logic [7:0] rd_data,
   output logic [7:0] wr_data,
   output logic wr_strobe
);

   // ----------------------------------------------------------------
   // Synchronisers and edge detection
   // ----------------------------------------------------------------
   logic [7:0] pin_m_r;
   logic [7:0] pin_s_r;
   logic scl_d_r;
   logic sda_d_r;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_m_r <= 8'h03;
         pin_s_r <= 8'h03;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         pin_m_r <= {addr_select_pin_hi, addr_select_pin_mid,
                     addr_select_pin_lo, scl_pin, sda_pin};
         pin_s_r <= pin_m_r;
         scl_d_r <= pin_s_r[1];
         sda_d_r <= pin_s_r[0];
      end
   end

   wire logic scl_s = pin_s_r[1];
   wire logic sda_s = pin_s_r[0];
   wire logic scl_rise = scl_s & ~scl_d_r;
   wire logic scl_fall = ~scl_s & scl_d_r;
   wire logic start_evt = scl_s & scl_d_r & sda_d_r & ~sda_s;
   wire logic stop_evt = scl_s & scl_d_r & ~sda_d_r & sda_s;
   logic tmo;

   mis_bus_timer #(.LIMIT(TIMEOUT_CYC), .CW(TMO_CNT_W)) u_timer (
      .clock(clock),
      .rst_n(rst_n),
      .scl_s(scl_s),
      .sda_s(sda_s),
      .expired(tmo)
   );

   // ----------------------------------------------------------------
   // Own address decode
   // ----------------------------------------------------------------
   function automatic logic [2:0] low3_of(input logic [1:0] r1,
                                          input logic [1:0] r0);
      logic [3:0] key;
      key = {r1, r0};
      case (key)
         {PIN_OPEN, PIN_LO}:   low3_of = 3'h0;
         {PIN_HI, PIN_OPEN}:   low3_of = 3'h1;
         {PIN_OPEN, PIN_OPEN}: low3_of = 3'h2;
         {PIN_OPEN, PIN_HI}:   low3_of = 3'h3;
         {PIN_LO, PIN_LO}:     low3_of = 3'h4;
         {PIN_HI, PIN_HI}:     low3_of = 3'h5;
         {PIN_LO, PIN_OPEN}:   low3_of = 3'h6;
         {PIN_LO, PIN_HI}:     low3_of = 3'h7;
         default:              low3_of = ADR_HL_LOW3;
      endcase
   endfunction

   wire logic [1:0] a2 = pin_s_r[7:6];
   wire logic [2:0] low3 = low3_of(pin_s_r[5:4], pin_s_r[3:2]);
   wire logic [1:0] hi2 = (a2 == PIN_LO) ? 2'h0 :
                          (a2 == PIN_HI) ? 2'h2 : 2'h1;
   wire logic [6:0] own_addr =
      {1'b1, hi2, low3[2], 1'b1, low3[1:0]};

   // ----------------------------------------------------------------
   // Address, command and transmit selection
   // ----------------------------------------------------------------
   mis_state_t state_r;
   logic [2:0] bit_cnt_r;
   logic got8_r;
   logic [7:0] shift_r;
   logic rw_r;
   logic ara_r;
   logic wfirst_r;
   logic nak_r;

   wire logic done8 = got8_r & scl_fall;
   wire logic own_hit = (shift_r[7:1] == own_addr);
   wire logic mass_hit = mass_write_en && (shift_r == MASS_WR_ADDR);
   wire logic ara_hit = alert_active &&
                        (shift_r == {ALERT_RESP_ADDR, 1'b1});
   wire logic addr_hit = own_hit | mass_hit | ara_hit;
   wire logic cmd_ok = (shift_r[7:3] == CMD_PAGE);
   wire logic [7:0] tx_first = ara_r ? {own_addr, 1'b0} : rd_data;
   wire logic rx_state = (state_r == ST_ADDR) || (state_r == ST_CMD) ||
                         (state_r == ST_WDAT);
   wire logic cnt_state = rx_state || (state_r == ST_TX);

   // ----------------------------------------------------------------
   // Protocol engine
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_IDLE;
         bit_cnt_r <= 3'h0;
         got8_r <= 1'b0;
         shift_r <= BYTE_RST;
         reg_ptr <= PTR_RST;
         rw_r <= 1'b0;
         ara_r <= 1'b0;
         wfirst_r <= 1'b0;
         nak_r <= 1'b0;
         serial_data_out_pin_oe <= 1'b0;
         wr_data <= BYTE_RST;
         wr_strobe <= 1'b0;
         alert_release <= 1'b0;
      end
      else
      begin
         wr_strobe <= 1'b0;
         alert_release <= 1'b0;
         if (tmo || stop_evt)
         begin
            state_r <= ST_IDLE;
            serial_data_out_pin_oe <= 1'b0;
         end
         else if (start_evt)
         begin
            state_r <= ST_ADDR;
            bit_cnt_r <= 3'h0;
            got8_r <= 1'b0;
            serial_data_out_pin_oe <= 1'b0;
         end
         else
         begin
            if (scl_rise && cnt_state)
            begin
               bit_cnt_r <= bit_cnt_r + 3'h1;
               got8_r <= (bit_cnt_r == BIT_LAST);
            end
            if (scl_rise && rx_state)
               shift_r <= {shift_r[6:0], sda_s};
            case (state_r)
               ST_IDLE:
                  state_r <= ST_IDLE;
               ST_ADDR:
                  if (done8)
                  begin
                     got8_r <= 1'b0;
                     if (addr_hit)
                     begin
                        serial_data_out_pin_oe <= 1'b1;
                        rw_r <= shift_r[0];
                        ara_r <= ara_hit;
                        state_r <= ST_AACK;
                     end
                     else
                        state_r <= ST_IDLE;
                  end
               ST_AACK:
                  if (scl_fall)
                  begin
                     bit_cnt_r <= 3'h0;
                     if (rw_r)
                     begin
                        shift_r <= tx_first;
                        serial_data_out_pin_oe <= ~tx_first[7];
                        state_r <= ST_TX;
                     end
                     else
                     begin
                        serial_data_out_pin_oe <= 1'b0;
                        state_r <= ST_CMD;
                     end
                  end
               ST_CMD:
                  if (done8)
                  begin
                     got8_r <= 1'b0;
                     if (cmd_ok)
                     begin
                        serial_data_out_pin_oe <= 1'b1;
                        reg_ptr <= shift_r[2:0];
                        state_r <= ST_CACK;
                     end
                     else
                        state_r <= ST_IDLE;
                  end
               ST_CACK:
                  if (scl_fall)
                  begin
                     serial_data_out_pin_oe <= 1'b0;
                     wfirst_r <= 1'b1;
                     state_r <= ST_WDAT;
                  end
               ST_WDAT:
                  if (done8)
                  begin
                     got8_r <= 1'b0;
                     serial_data_out_pin_oe <= 1'b1;
                     wfirst_r <= 1'b0;
                     state_r <= ST_WACK;
                     if (wfirst_r)
                     begin
                        wr_data <= shift_r;
                        wr_strobe <= 1'b1;
                     end
                  end
               ST_WACK:
                  if (scl_fall)
                  begin
                     serial_data_out_pin_oe <= 1'b0;
                     state_r <= ST_WDAT;
                  end
               ST_TX:
                  if (scl_fall)
                  begin
                     if (got8_r)
                     begin
                        got8_r <= 1'b0;
                        serial_data_out_pin_oe <= 1'b0;
                        alert_release <= ara_r;
                        state_r <= ST_MACK;
                     end
                     else
                     begin
                        shift_r <= {shift_r[6:0], 1'b1};
                        serial_data_out_pin_oe <= ~shift_r[6];
                     end
                  end
               ST_MACK:
                  if (scl_rise)
                  begin
                     nak_r <= sda_s;
                     // Advance early so rd_data settles before SCL falls
                     if (!sda_s && !ara_r)
                        reg_ptr <= reg_ptr + 3'h1;
                  end
                  else if (scl_fall)
                  begin
                     if (nak_r || ara_r)
                        state_r <= ST_IDLE;
                     else
                     begin
                        bit_cnt_r <= 3'h0;
                        shift_r <= rd_data;
                        serial_data_out_pin_oe <= ~rd_data[7];
                        state_r <= ST_TX;
                     end
                  end
               default:
                  state_r <= ST_IDLE;
            endcase
         end
      end
   end

   // Open drain: the pin only ever pulls low
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         serial_data_out_pin <= 1'b0;
      else
         serial_data_out_pin <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   addr_ack_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state_r == ST_ADDR && done8 && own_hit && !tmo && !stop_evt &&
       !start_evt) |=> serial_data_out_pin_oe && state_r == ST_AACK)
      else $error("own address not acknowledged");

   word_rd_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state_r == ST_MACK && scl_rise && !sda_s && !ara_r && !tmo &&
       !stop_evt && !start_evt) |=> reg_ptr == $past(reg_ptr) + 3'h1)
      else $error("word read pointer did not advance");

   wr_once_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state_r == ST_WDAT && done8 && !wfirst_r) |=> !wr_strobe)
      else $error("second write byte was stored");

   tmo_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
      tmo |=> state_r == ST_IDLE && !serial_data_out_pin_oe)
      else $error("timeout did not reset interface");

   cmd_nack_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state_r == ST_CMD && done8 && !cmd_ok && !tmo && !stop_evt &&
       !start_evt) |=> !serial_data_out_pin_oe [*2])
      else $error("bad command acknowledged");

   start_det_a: assert property (@(posedge clock) disable iff (!rst_n)
      (start_evt && !tmo) |=> state_r == ST_ADDR && bit_cnt_r == 3'h0)
      else $error("start not detected");

   stop_det_a: assert property (@(posedge clock) disable iff (!rst_n)
      stop_evt |=> state_r == ST_IDLE && !serial_data_out_pin_oe)
      else $error("stop not detected");

   ptr_load_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state_r == ST_CMD && done8 && cmd_ok && !tmo && !stop_evt &&
       !start_evt) |=> reg_ptr == $past(shift_r[2:0]))
      else $error("pointer not loaded from command");

   mass_off_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state_r == ST_ADDR && done8 && !mass_write_en && !own_hit &&
       shift_r == MASS_WR_ADDR) |=> !serial_data_out_pin_oe)
      else $error("mass write answered while disabled");

   ara_rel_a: assert property (@(posedge clock) disable iff (!rst_n)
      alert_release |-> ara_r && state_r == ST_MACK)
      else $error("alert released outside alert response");

endmodule // mis_i2c_slave

// ===== mis_master_model.sv
/*
 * Bus master model: drives the clock and data lines of the two-wire bus.
 * Assumes the bench resolves the open-drain data line with a pull-up.
 */
`timescale 1ns/1ps
module mis_master_model
(
   // Bench clock, paces the link
   input wire logic clock,
   // Bus lines; an output at 1 means released
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_out
);
   initial
   begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end

   // Quarter of the 160 ns link period
   task automatic step();
      repeat (2) @(negedge clock);
   endtask

   // Works from idle and as a repeated start; leaves clock low
   task automatic start();
      sda_out = 1'b1;
      step();
      scl_out = 1'b1;
      step();
      sda_out = 1'b0;
      step();
      scl_out = 1'b0;
      step();
   endtask

   task automatic stop();
      sda_out = 1'b0;
      step();
      scl_out = 1'b1;
      step();
      sda_out = 1'b1;
      step();
   endtask

   task automatic clock_bit(input logic b, output logic r);
      sda_out = b;
      step();
      scl_out = 1'b1;
      step();
      r = sda_in;
      step();
      scl_out = 1'b0;
      step();
   endtask

   task automatic send_bits(input logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
         clock_bit(b[i], r);
   endtask

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic r;
      send_bits(b);
      clock_bit(1'b1, r);
      ack = ~r;
   endtask

   task automatic recv_byte(input logic mack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
         clock_bit(1'b1, b[i]);
      clock_bit(~mack, r);
   endtask
endmodule // mis_master_model

// ===== mis_i2c_slave_test.sv
/*
 * Self-checking bench for the two-wire slave with a master model and a
 * small register file. Assumes a shortened timeout of 200 cycles.
 */
`timescale 1ns/1ps
module mis_i2c_slave_test;
   import mis_pkg::*;
   logic clock;
   logic rst_n;
   logic scl_pin;
   logic sda_pin;
   logic m_sda;
   logic sdo;
   logic sdo_oe;
   logic [5:0] straps;
   logic alert_active;
   logic mass_write_en;
   logic alert_release;
   logic [2:0] reg_ptr;
   logic [7:0] wr_data;
   logic wr_strobe;
   logic [7:0] dev_regs [8];
   logic [7:0] exp_regs [8];
   logic [11:0] notes [$];
   logic [7:0] own8;
   // Mixed straps {hi, mid, lo} and the address each one selects
   logic [5:0] strap_set [4] = '{{PIN_LO, PIN_HI, PIN_OPEN},
      {PIN_LO, PIN_OPEN, PIN_HI}, {PIN_LO, PIN_LO, PIN_HI},
      {PIN_HI, PIN_OPEN, PIN_LO}};
   logic [7:0] strap_adr [4] = '{8'h8A, 8'h8E, 8'h9E, 8'hC8};
   logic [7:0] bad_cmd [5] = '{8'h00, 8'h88, 8'hCF, 8'hD8, 8'hFF};
   int fails = 0;
   int total_checks = 0;
   int cycles = 0;
   int seed;

   // Open-drain data line with pull-up
   assign sda_pin = m_sda & (sdo_oe ? sdo : 1'b1);

   mis_master_model m (.clock(clock), .sda_in(sda_pin), .scl_out(scl_pin),
      .sda_out(m_sda));

   mis_i2c_slave #(.TIMEOUT_CYC(200)) dut (.clock(clock), .rst_n(rst_n),
      .scl_pin(scl_pin), .sda_pin(sda_pin), .serial_data_out_pin(sdo),
      .serial_data_out_pin_oe(sdo_oe), .addr_select_pin_lo(straps[1:0]),
      .addr_select_pin_mid(straps[3:2]), .addr_select_pin_hi(straps[5:4]),
      .alert_active(alert_active), .mass_write_en(mass_write_en),
      .alert_release(alert_release), .reg_ptr(reg_ptr),
      .rd_data(dev_regs[reg_ptr]), .wr_data(wr_data), .wr_strobe(wr_strobe));

   always #10 clock = ~clock;

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic compare_bit(input logic act, input logic exp, string s);
      total_checks++;
      if (act !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, s);
      end
   endtask

   task automatic compare_data(input logic [11:0] act, exp, string s);
      total_checks++;
      if (act !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: %s %h/%h", $time, s, act, exp);
      end
   endtask

   // Write byte, or word when word is set
   task automatic do_write(input logic [7:0] adr, cmd, dat,
      input logic word, aack, cack);
      logic a;
      m.start();
      m.send_byte(adr, a);
      compare_bit(a, aack, "address ack");
      if (a)
      begin
         m.send_byte(cmd, a);
         compare_bit(a, cack, "command ack");
      end
      if (a)
      begin
         notes.push_back({1'b0, cmd[2:0], dat});
         exp_regs[cmd[2:0]] = dat;
         m.send_byte(dat, a);
         compare_bit(a, 1'b1, "data ack");
         if (word)
            m.send_byte(~dat, a);
         compare_bit(a, 1'b1, "second byte ack");
      end
      m.stop();
   endtask

   task automatic do_read(input logic [7:0] cmd, input logic word);
      logic a;
      logic [7:0] b;
      m.start();
      m.send_byte(own8, a);
      m.send_byte(cmd, a);
      m.start();
      m.send_byte(own8 | 8'h01, a);
      compare_bit(a, 1'b1, "read address ack");
      m.recv_byte(word, b);
      compare_data(12'(b), 12'(exp_regs[cmd[2:0]]), "first byte");
      if (word)
         m.recv_byte(1'b0, b);
      if (word)
         compare_data(12'(b), 12'(exp_regs[3'(cmd + 1)]), "next byte");
      m.stop();
   endtask

   task automatic do_alert(input logic exp);
      logic a;
      logic [7:0] b;
      m.start();
      m.send_byte(8'h19, a);
      compare_bit(a, exp, "alert address ack");
      if (a)
         notes.push_back(12'h800);
      if (a)
         m.recv_byte(1'b0, b);
      if (a)
         compare_data(12'(b), 12'(own8), "alert answer");
      m.stop();
   endtask

   // Register file and result monitor
   always @(negedge clock)
   begin
      if (wr_strobe === 1'b1)
         dev_regs[reg_ptr] <= wr_data;
      if (wr_strobe === 1'b1 || alert_release === 1'b1)
      begin
         if (notes.size() == 0)
            compare_bit(1'b1, 1'b0, "unexpected result");
         else
            compare_data(alert_release ? 12'h800 : {1'b0, reg_ptr, wr_data},
               notes.pop_front(), "result");
      end
   end

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fails++;
         $display("CHECK FAILED at %0t: run too long", $time);
         complete_run();
      end
   end

   initial
   begin
      seed = 32'ha81d;
      clock = 1'b0;
      rst_n = 1'b0;
      straps = {3{PIN_LO}};
      own8 = 8'h98;
      alert_active = 1'b0;
      mass_write_en = 1'b1;
      for (int i = 0; i < 8; i++)
         exp_regs[i] = 8'($random(seed));
      dev_regs = exp_regs;
      repeat (5) @(negedge clock);
      rst_n = 1'b1;
      compare_bit(sdo_oe, 1'b0, "oe after reset");
      repeat (4) @(negedge clock);
      // Each write spans over 200 cycles, so the stuck timer must restart
      for (int i = 0; i < 8; i++)
         do_write(own8, 8'hD0 | 8'(i), 8'($random(seed)), 0, 1, 1);
      foreach (bad_cmd[i])
         do_write(own8, bad_cmd[i], 8'h5A, 0, 1, 0);
      $display("byte writes and refused commands done");
      do_write(own8, 8'hD5, 8'($random(seed)), 1, 1, 1);
      do_read(8'hD5, 1);
      do_read(8'hD7, 1);
      do_read(8'hD2, 0);
      $display("word transfers done");
      do_write(8'hC6, 8'hD1, 8'($random(seed)), 0, 1, 1);
      mass_write_en = 1'b0;
      do_write(8'hC6, 8'hD1, 8'h33, 0, 0, 0);
      mass_write_en = 1'b1;
      do_write(8'hAC, 8'hD4, 8'h33, 0, 0, 0);
      straps = {3{PIN_OPEN}};
      repeat (4) @(negedge clock);
      do_write(8'hAC, 8'hD4, 8'($random(seed)), 0, 1, 1);
      do_write(own8, 8'hD4, 8'h33, 0, 0, 0);
      // Unequal pins catch a swapped or misread strap decode
      foreach (strap_set[i])
      begin
         straps = strap_set[i];
         repeat (4) @(negedge clock);
         do_write(strap_adr[i], 8'hD3, 8'($random(seed)), 0, 1, 1);
      end
      straps = {3{PIN_LO}};
      repeat (4) @(negedge clock);
      $display("special and strapped addresses done");
      do_alert(1'b0);
      alert_active = 1'b1;
      do_alert(1'b1);
      alert_active = 1'b0;
      m.start();
      m.send_bits(own8);
      repeat (150) @(negedge clock);
      compare_bit(sdo_oe, 1'b1, "ack held before timeout");
      repeat (70) @(negedge clock);
      compare_bit(sdo_oe, 1'b0, "released by timeout");
      m.stop();
      do_read(8'hD4, 0);
      repeat (10) @(negedge clock);
      compare_data(12'(notes.size()), 12'h000, "results left");
      $display("timeout test done");
      complete_run();
   end
endmodule // mis_i2c_slave_test
